// [hdl/phy_lat_pkg.sv]
// package with offsets, fields and reset values for the pipe control and exit latency registers
package phy_lat_pkg;
  localparam logic [11:0] pipe_ctl_off = 12'h09c;
  localparam logic [11:0] u1_exit_latency_off = 12'h0a0;
  localparam logic [11:0] u2_exit_latency_off = 12'h0a4;
  localparam logic [11:0] sel_status_off = 12'h0a8;
  localparam int swing_bit = 0;
  localparam int margin_lo = 1;
  localparam int margin_hi = 3;
  localparam int deemph_lo = 4;
  localparam int deemph_hi = 5;
  localparam int ebuf_bit = 6;
  localparam int set_sel_bit = 5;
  localparam int u1_dh_lo = 16;
  localparam int u1_sys_lo = 0;
  localparam int u2_dh_lo = 16;
  localparam int u2_sys_lo = 0;
  localparam logic [6:0] pipe_zero = 7'h00;
  localparam logic [7:0] lat8_rst = 8'h00;
  localparam logic [15:0] lat16_rst = 16'h0000;
  localparam logic [31:0] rd_zero = 32'h0000_0000;
  typedef enum logic [1:0] {src_eeprom, src_otp, src_none} img_src_e;
endpackage : phy_lat_pkg

// [hdl/pipe_default_sel.sv]
// picks the pipe setting image from eeprom, otp or zero
`timescale 1ns/1ps
`default_nettype none
module pipe_default_sel (
  // sources
  input wire logic eeprom_present_i,
  input wire logic [6:0] eeprom_flags_i,
  input wire logic otp_programmed_i,
  input wire logic [6:0] otp_flags_i,
  // result
  output logic [6:0] image_o,
  output var phy_lat_pkg::img_src_e src_o
);
  import phy_lat_pkg::*;
  assign src_o = eeprom_present_i ? src_eeprom : (otp_programmed_i ? src_otp : src_none);
  assign image_o = eeprom_present_i ? eeprom_flags_i :
                   otp_programmed_i ? otp_flags_i :
                   pipe_zero;
endmodule : pipe_default_sel
`default_nettype wire

// [hdl/usb_phy_ctl_lat_regs.sv]
// pipe control settings, u1/u2 exit latency and set sel status registers on apb
//
// Overview of operation
// - pipe fields default from eeprom flags
// - without eeprom, defaults from otp image
// - neither source present: fields reset zero
// - usb or lite reset restores loaded image
// - protected resets leave swing/margin/deemphasis unchanged
// - compliance mode: deemphasis from link training
// - buffer mode stored but unused
// - u1 device-to-host latency bits 23:16
// - u1 system latency bits 7:0
// - u2 device-to-host latency bits 31:16
// - u2 system latency bits 15:0
// - latencies written only by set sel
// - set sel sets status bit 5, write-clear
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module usb_phy_ctl_lat_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // configuration image
  input wire logic load_image_i,
  input wire logic eeprom_present_i,
  input wire logic [6:0] eeprom_flags_i,
  input wire logic otp_programmed_i,
  input wire logic [6:0] otp_flags_i,
  // usb resets
  input wire logic usb_reset_i,
  input wire logic lite_soft_reset_i,
  input wire logic reset_protect_i,
  // link training
  input wire logic compliance_mode_i,
  input wire logic [1:0] ltssm_deemph_i,
  // set sel from host
  input wire logic set_sel_i,
  input wire logic [7:0] u1_dev_to_host_lat_i,
  input wire logic [7:0] u1_system_lat_i,
  input wire logic [15:0] u2_dev_to_host_lat_i,
  input wire logic [15:0] u2_system_lat_i,
  // pipe outputs to phy
  output logic tx_swing_o,
  output logic [2:0] tx_margin_o,
  output logic [1:0] tx_deemph_o,
  output logic ebuf_mode_o
);
  import phy_lat_pkg::*;

  logic [6:0] pipe_ctl;
  logic [6:0] image;
  logic [6:0] image_now;
  img_src_e src_now;
  img_src_e image_src;
  logic [7:0] u1_dev_to_host_lat;
  logic [7:0] u1_system_lat;
  logic [15:0] u2_dev_to_host_lat;
  logic [15:0] u2_system_lat;
  logic set_sel_sts;

  pipe_default_sel u_sel (
    .eeprom_present_i(eeprom_present_i),
    .eeprom_flags_i(eeprom_flags_i),
    .otp_programmed_i(otp_programmed_i),
    .otp_flags_i(otp_flags_i),
    .image_o(image_now),
    .src_o(src_now)
  );

  // apb decode
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire hit_pipe = paddr_i == pipe_ctl_off;
  wire hit_u1 = paddr_i == u1_exit_latency_off;
  wire hit_u2 = paddr_i == u2_exit_latency_off;
  wire hit_sts = paddr_i == sel_status_off;
  wire mapped = hit_pipe || hit_u1 || hit_u2 || hit_sts;
  wire pipe_wr = wr && hit_pipe;
  wire sts_clr = wr && hit_sts && pwdata_i[set_sel_bit];
  wire soft_rst = usb_reset_i || lite_soft_reset_i;
  // protected bits: swing, margin, deemphasis
  wire [6:0] prot_mask = 7'h3f;
  wire [6:0] keep_mask = reset_protect_i ? prot_mask : pipe_zero;
  // restore value, zero when no source was loaded
  wire [6:0] restore_img = (image_src == src_none) ? pipe_zero : image;

  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  // read mux
  wire [31:0] rd_pipe = {25'h000_0000, pipe_ctl};
  wire [31:0] rd_u1 = {8'h00, u1_dev_to_host_lat, 8'h00, u1_system_lat};
  wire [31:0] rd_u2 = {u2_dev_to_host_lat, u2_system_lat};
  wire [31:0] rd_sts = {26'h000_0000, set_sel_sts, 5'h00};
  wire [31:0] rd_data = hit_pipe ? rd_pipe : hit_u1 ? rd_u1 : hit_u2 ? rd_u2 :
                        hit_sts ? rd_sts : rd_zero;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      prdata_o <= rd_zero;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_data;
    end
  end

  // image capture after power-up load
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      image <= pipe_zero;
      image_src <= src_none;
    end else if (load_image_i) begin
      image <= image_now;
      image_src <= src_now;
    end
  end

  // pipe control register
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pipe_ctl <= pipe_zero;
    end else if (load_image_i) begin
      pipe_ctl <= image_now;
    end else if (soft_rst) begin
      pipe_ctl <= (pipe_ctl & keep_mask) | (restore_img & ~keep_mask);
    end else if (pipe_wr) begin
      pipe_ctl <= pwdata_i[6:0];
    end
  end

  // exit latencies, host only
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      u1_dev_to_host_lat <= lat8_rst;
      u1_system_lat <= lat8_rst;
      u2_dev_to_host_lat <= lat16_rst;
      u2_system_lat <= lat16_rst;
    end else if (set_sel_i) begin
      u1_dev_to_host_lat <= u1_dev_to_host_lat_i;
      u1_system_lat <= u1_system_lat_i;
      u2_dev_to_host_lat <= u2_dev_to_host_lat_i;
      u2_system_lat <= u2_system_lat_i;
    end
  end

  // set sel status, set wins over clear
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      set_sel_sts <= 1'b0;
    end else if (set_sel_i) begin
      set_sel_sts <= 1'b1;
    end else if (sts_clr) begin
      set_sel_sts <= 1'b0;
    end
  end

  // pipe outputs
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tx_swing_o <= 1'b0;
      tx_margin_o <= 3'h0;
      tx_deemph_o <= 2'h0;
      ebuf_mode_o <= 1'b0;
    end else begin
      tx_swing_o <= pipe_ctl[swing_bit];
      tx_margin_o <= pipe_ctl[margin_hi:margin_lo];
      tx_deemph_o <= compliance_mode_i ? ltssm_deemph_i : pipe_ctl[deemph_hi:deemph_lo];
      ebuf_mode_o <= 1'b0;
    end
  end
endmodule : usb_phy_ctl_lat_regs
`default_nettype wire

// [bench/usb_phy_ctl_lat_regs_monitor.sv]
// assertions on the register block ports
`timescale 1ns/1ps
`default_nettype none
module usb_phy_ctl_lat_regs_monitor
  import phy_lat_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic load_image_i,
  input wire logic reset_protect_i,
  input wire logic compliance_mode_i,
  input wire logic [1:0] ltssm_deemph_i,
  input wire logic set_sel_i,
  input wire logic [7:0] u1_system_lat_i,
  input wire logic tx_swing_o,
  input wire logic [1:0] tx_deemph_o,
  input wire logic ebuf_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic rd = psel_i && penable_i && !pwrite_i;
  wire logic u1 = paddr_i == u1_exit_latency_off;
  wire logic hit = paddr_i inside {pipe_ctl_off, u1_exit_latency_off, u2_exit_latency_off,
    sel_status_off};
  a_ebuf_unused: assert property (!ebuf_mode_o) else $error("ebuf set");
  a_deemph_link: assert property ((compliance_mode_i && $stable(ltssm_deemph_i))[*3] |->
    tx_deemph_o == ltssm_deemph_i) else $error("deemph not link");
  a_swing_kept: assert property ((reset_protect_i && !load_image_i && !psel_i)[*2] |=>
    $stable(tx_swing_o)) else $error("swing moved");
  a_u1_resvd: assert property (rd && u1 |-> prdata_o[31:24] == 8'h00 &&
    prdata_o[15:8] == 8'h00) else $error("u1 reserved");
  a_u1_sys: assert property (rd && u1 && $past(set_sel_i, 3) |->
    prdata_o[7:0] == $past(u1_system_lat_i, 3)) else $error("u1 system");
  a_ready_high: assert property (pready_o) else $error("pready low");
  a_err_map: assert property (psel_i && penable_i |-> pslverr_o == !hit) else $error("pslverr");
  a_unmap_zero: assert property (rd && !hit |-> prdata_o == 32'h0000_0000) else $error("rd");
  c_set_sel: cover property (set_sel_i);
  c_compl: cover property (compliance_mode_i && tx_deemph_o == ltssm_deemph_i);
  c_unmap: cover property (pslverr_o);
endmodule : usb_phy_ctl_lat_regs_monitor
bind usb_phy_ctl_lat_regs usb_phy_ctl_lat_regs_monitor mon (.mclk_i, .rst_b_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .load_image_i,
  .reset_protect_i, .compliance_mode_i, .ltssm_deemph_i, .set_sel_i, .u1_system_lat_i,
  .tx_swing_o, .tx_deemph_o, .ebuf_mode_o);
`default_nettype wire

// [bench/set_sel_host.sv]
// host model that issues set sel with exit latencies
`timescale 1ns/1ps
`default_nettype none
module set_sel_host (
  // clock
  input wire logic mclk_i,
  // set sel request
  output logic set_sel_o,
  output logic [47:0] lat_o
);
  initial begin
    set_sel_o = 1'b0;
    lat_o = '0;
  end
  task send(input logic [47:0] v);
    @(posedge mclk_i);
    set_sel_o <= 1'b1;
    lat_o <= v;
    @(posedge mclk_i);
    set_sel_o <= 1'b0;
    lat_o <= ~v;
  endtask : send
endmodule : set_sel_host
`default_nettype wire

// [bench/test_usb_phy_ctl_lat_regs.sv]
// self-checking bench for the pipe control and exit latency registers
`timescale 1ns/1ps
`default_nettype none
module test_usb_phy_ctl_lat_regs;
  import phy_lat_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, psel = 0, pen = 0, pwr = 0, ld = 0, eep = 0, otp = 0;
  logic urst = 0, lite_soft_reset = 0, prot = 0, cmpl = 0, ss, rdy, perr, sw, eb, pe;
  logic [11:0] pa = 0;
  logic [31:0] pw = 0, prd, r;
  logic [6:0] ef = 0, of = 0, img;
  logic [1:0] lt = 0, de;
  logic [2:0] mg;
  logic [47:0] lat, v;
  int error_cnt = 0, cmp_count = 0, seed = 8881, u1, u2;
  always #4 mclk_i = ~mclk_i;
  set_sel_host host (.mclk_i(mclk_i), .set_sel_o(ss), .lat_o(lat));
  usb_phy_ctl_lat_regs uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(perr), .load_image_i(ld), .eeprom_present_i(eep), .eeprom_flags_i(ef),
    .otp_programmed_i(otp), .otp_flags_i(of), .usb_reset_i(urst), .lite_soft_reset_i(lite_soft_reset),
    .reset_protect_i(prot), .compliance_mode_i(cmpl), .ltssm_deemph_i(lt), .set_sel_i(ss),
    .u1_dev_to_host_lat_i(lat[47:40]), .u1_system_lat_i(lat[39:32]),
    .u2_dev_to_host_lat_i(lat[31:16]), .u2_system_lat_i(lat[15:0]), .tx_swing_o(sw),
    .tx_margin_o(mg), .tx_deemph_o(de), .ebuf_mode_o(eb));
  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {psel, pen, pwr, pa, pw} <= {2'b10, w, a, d};
    @(posedge mclk_i);
    pen <= 1'b1;
    @(posedge mclk_i);
    while (rdy !== 1'b1) @(posedge mclk_i);
    r = prd;
    pe = perr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    apb(0, u2_exit_latency_off, 0);
    chk("u2 rst", r, 0);
    apb(0, 12'h0b0, 0);
    chk("unmapped rd", r, 0);
    chk("slverr", {31'h0, pe}, 1);
    for (int s = 2; s >= 0; s--) begin
      {ef, of} <= 14'($random(seed));
      {eep, otp} <= {s == 0, s < 2};
      @(posedge mclk_i);
      ld <= 1'b1;
      @(posedge mclk_i);
      ld <= 1'b0;
      img = s == 0 ? ef : s == 1 ? of : 7'h00;
      apb(0, pipe_ctl_off, 0);
      chk("image", r, {25'h0, img});
      chk("pins", {eb, de, mg, sw}, {1'b0, img[5:0]});
    end
    for (int k = 0; k < 4; k++) begin
      apb(1, pipe_ctl_off, {25'h0, ~img});
      {prot, urst, lite_soft_reset} <= {k[1], !k[0], k[0]};
      @(posedge mclk_i);
      {urst, lite_soft_reset} <= 2'b00;
      apb(0, pipe_ctl_off, 0);
      chk("restore", r, {25'h0, k[1] ? {img[6], ~img[5:0]} : img});
    end
    {lt, cmpl} <= {~de, 1'b1};
    repeat (5) @(posedge mclk_i);
    chk("ltssm", de, lt);
    cmpl <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      v = 48'({$random(seed), $random(seed)});
      u1 = {8'h00, v[47:40], 8'h00, v[39:32]};
      u2 = v[31:0];
      host.send(v);
      apb(0, u1_exit_latency_off, 0);
      chk("u1", r, u1);
      apb(1, u1_exit_latency_off, 32'hffff_ffff);
      apb(1, u2_exit_latency_off, 32'h0000_0000);
      apb(0, u1_exit_latency_off, 0);
      chk("u1 ro", r, u1);
      apb(0, u2_exit_latency_off, 0);
      chk("u2", r, u2);
      apb(0, sel_status_off, 0);
      chk("sel", r, 32'h0000_0020);
      apb(1, sel_status_off, 32'h0000_0020);
      apb(0, sel_status_off, 0);
      chk("sel clr", r, 0);
    end
    finish_test;
  end
endmodule : test_usb_phy_ctl_lat_regs
`default_nettype wire
